// >>> hdl/ecr_eeprom_ctrl.sv
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
// eeprom store / restore control with apb register access
module ecr_eeprom_ctrl #(
   parameter logic [ecr_pkg::TMR_W-1:0] WRITE_OSC_P = ecr_pkg::WRITE_OSC
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire ecr_pkg::ecr_apb_req_s apb_in,
   output logic                       pready_out,
   output logic [31:0]                prdata_out,
   output logic                       pslverr_out,
   output ecr_pkg::ecr_eep_s          eep_out,
   input  wire logic [ecr_pkg::EEP_W-1:0] eep_data_in,
   output logic                       v1_from_eeprom_out
);
   import ecr_pkg::*;

   typedef enum {ST_IDLE, ST_ENTER, ST_MODE, ST_WRITE, ST_READ} ecr_state_e;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ecr_state_e         state, next_state;       // eeprom sequencer
   logic               mode_rd, next_mode_rd;   // mode entered for read
   logic               osc_on, next_osc_on;     // oscillator running
   logic               test_st, next_test_st;   // factory test state
   logic               sel_two, next_sel_two;   // readback source
   logic [VOL_W-1:0]   volume, next_volume;     // contrast volume
   logic [RATIO_W-1:0] ratio, next_ratio;       // resistor ratio
   logic [7:0]         power, next_power;       // power circuit control
   logic [EEP_W-1:0]   rd_word, next_rd_word;   // word read from eeprom
   logic               rd_valid, next_rd_valid; // rd_word holds data
   ecr_eep_s           next_eep;                // eeprom pin values
   logic [31:0]        next_prdata;
   logic               next_pslverr;
   logic [EEP_W-1:0]   eep_meta, eep_sync;      // input synchroniser
   logic               tmr_start;               // timer reload
   logic [TMR_W-1:0]   tmr_load;                // osc periods to wait
   logic               tmr_done;                // operation finished
   logic               wr_acc, rd_acc;          // apb access phase
   logic               cmd_hit;                 // command written
   logic               ack_wait, next_ack_wait; // ready cycle of access
   logic               acc_first;               // first access cycle
   ecr_cmd_e           cmd;
   logic               busy;                    // eeprom_access_busy_bit

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic addr_is(input logic [7:0] a,
                                    input logic [7:0] b);
      return a == b;
   endfunction : addr_is

   function automatic logic [31:0] pad(input logic [EEP_W-1:0] v);
      return {{(32-EEP_W){1'b0}}, v};
   endfunction : pad

   // ------------------------------------------------------------
   // processing timer
   // ------------------------------------------------------------
   ecr_timer u_timer (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .osc_run_in (osc_on),
      .start_in   (tmr_start),
      .load_in    (tmr_load),
      .done_out   (tmr_done)
   );

   // ------------------------------------------------------------
   // apb decode, one wait state so read data come from flops
   // ------------------------------------------------------------
   assign pready_out = ack_wait;                   // ready in 2nd cycle
   assign acc_first  = apb_in.psel && apb_in.penable && !ack_wait;
   assign wr_acc  = apb_in.psel && apb_in.penable && apb_in.pwrite
                    && ack_wait;                   // lands at ready edge
   assign rd_acc  = acc_first && !apb_in.pwrite;   // data ready next cycle
   assign cmd_hit = wr_acc && addr_is(apb_in.paddr, ADDR_CMD);
   assign cmd     = ecr_cmd_e'(apb_in.pwdata[CMD_W-1:0]);
   assign busy    = (state == ST_ENTER) || (state == ST_WRITE)
                    || (state == ST_READ);
   assign v1_from_eeprom_out = !power[PWR_SRC_POS];

   // ------------------------------------------------------------
   // next values of the whole block
   // ------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_mode_rd  = mode_rd;
      next_osc_on   = osc_on;
      next_test_st  = test_st;
      next_sel_two  = sel_two;
      next_volume   = volume;
      next_ratio    = ratio;
      next_power    = power;
      next_rd_word  = rd_word;
      next_rd_valid = rd_valid;
      next_eep      = eep_out;
      next_prdata   = prdata_out;
      next_pslverr  = 1'b0;
      next_ack_wait = acc_first;
      tmr_start     = 1'b0;
      tmr_load      = ENTER_OSC;

      // operation finished: busy drops
      if (tmr_done) begin
         if (state == ST_READ) begin
            next_rd_word  = eep_sync;
            next_rd_valid = 1'b1;
         end
         next_eep.write_en = 1'b0;
         next_eep.read_en  = 1'b0;
         next_state        = ST_MODE;
      end

      // register writes
      if (wr_acc) begin
         if (addr_is(apb_in.paddr, ADDR_VOLUME)) begin
            // volume set, refused while eeprom busy
            if (!busy) begin
               next_volume = apb_in.pwdata[VOL_W-1:0];
               next_ratio  = apb_in.pwdata[EEP_W-1:VOL_W];
            end
         end else if (addr_is(apb_in.paddr, ADDR_POWER)) begin
            next_power = apb_in.pwdata[7:0];
         end
      end

      // write error, registered ahead of the ready edge
      if (acc_first && apb_in.pwrite) begin
         next_pslverr = !(addr_is(apb_in.paddr, ADDR_CMD)
                          || addr_is(apb_in.paddr, ADDR_VOLUME)
                          || addr_is(apb_in.paddr, ADDR_POWER));
      end

      // commands; all ignored while eeprom busy
      if (cmd_hit && !busy) begin
         case (cmd)
            CMD_NOP: begin
               next_test_st = 1'b0;
            end
            CMD_OSC_ON: begin
               next_osc_on = 1'b1;
            end
            CMD_OSC_OFF: begin
               next_osc_on = 1'b0;
            end
            CMD_ENTER_WR, CMD_ENTER_RD: begin
               if (state == ST_IDLE) begin
                  next_state    = ST_ENTER;
                  next_mode_rd  = (cmd == CMD_ENTER_RD);
                  next_rd_valid = 1'b0;
                  tmr_start     = 1'b1;
                  tmr_load      = ENTER_OSC;
               end
            end
            CMD_MEM_WRITE: begin
               if (state == ST_MODE && !mode_rd) begin
                  next_state        = ST_WRITE;
                  next_eep.data     = {ratio, volume};
                  next_eep.write_en = 1'b1;
                  tmr_start         = 1'b1;
                  tmr_load          = WRITE_OSC_P;
               end
            end
            CMD_MEM_READ: begin
               if (state == ST_MODE && mode_rd) begin
                  next_state       = ST_READ;
                  next_eep.read_en = 1'b1;
                  tmr_start        = 1'b1;
                  tmr_load         = READ_OSC;
               end
            end
            CMD_MODE_EXIT: begin
               if (state == ST_MODE) begin
                  next_state = ST_IDLE;
                  if (mode_rd && rd_valid) begin
                     next_volume = rd_word[VOL_W-1:0];
                     next_ratio  = rd_word[EEP_W-1:VOL_W];
                  end
               end
            end
            CMD_SEL_ONE: begin
               next_sel_two = 1'b0;
            end
            CMD_SEL_TWO: begin
               next_sel_two = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // register reads
      if (rd_acc) begin
         if (addr_is(apb_in.paddr, ADDR_VOLUME)) begin
            next_prdata = pad({ratio, volume});
         end else if (addr_is(apb_in.paddr, ADDR_POWER)) begin
            next_prdata = {24'h000000, power};
         end else if (addr_is(apb_in.paddr, ADDR_STATUS)) begin
            next_prdata = '0;
            next_prdata[ST_OSC_POS]  = osc_on;
            next_prdata[ST_MODE_POS] = (state != ST_IDLE);
            next_prdata[ST_BUSY_POS] = busy;
            next_prdata[ST_TEST_POS] = test_st;
            next_prdata[ST_SEL_POS]  = sel_two;
         end else if (addr_is(apb_in.paddr, ADDR_READBACK)) begin
            next_prdata = sel_two ? pad({6'h00, ratio})
                                  : pad({3'h0, volume});
         end else if (addr_is(apb_in.paddr, ADDR_CMD)) begin
            next_prdata = '0;
         end else begin
            next_prdata  = '0;
            next_pslverr = 1'b1;                       // unmapped
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      // eeprom data pins, two flops before use
      eep_meta <= eep_data_in;
      eep_sync <= eep_meta;
      if (reset_in) begin
         state       <= ST_IDLE;
         mode_rd     <= 1'b0;
         osc_on      <= 1'b0;
         test_st     <= 1'b1;
         sel_two     <= 1'b0;
         volume      <= RST_VOLUME;
         ratio       <= RST_RATIO;
         power       <= RST_POWER;
         rd_word     <= '0;
         rd_valid    <= 1'b0;
         eep_out     <= '0;
         prdata_out  <= '0;
         pslverr_out <= 1'b0;
         ack_wait    <= 1'b0;
      end else begin
         state       <= next_state;
         mode_rd     <= next_mode_rd;
         osc_on      <= next_osc_on;
         test_st     <= next_test_st;
         sel_two     <= next_sel_two;
         volume      <= next_volume;
         ratio       <= next_ratio;
         power       <= next_power;
         rd_word     <= next_rd_word;
         rd_valid    <= next_rd_valid;
         eep_out     <= next_eep;
         prdata_out  <= next_prdata;
         pslverr_out <= next_pslverr;
         ack_wait    <= next_ack_wait;
      end
   end

endmodule : ecr_eeprom_ctrl

// >>> hdl/ecr_pkg.sv
package ecr_pkg;

   // ---------------------------------------------------------------
   // register map, byte addresses on the apb bus
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CMD      = 8'h00; // command code, write only
   localparam logic [7:0] ADDR_VOLUME   = 8'h04; // contrast volume and ratio
   localparam logic [7:0] ADDR_POWER    = 8'h08; // power circuit control
   localparam logic [7:0] ADDR_STATUS   = 8'h0c; // device state, read only
   localparam logic [7:0] ADDR_READBACK = 8'h10; // volume or ratio readback value

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int VOL_W        = 6;  // contrast volume width
   localparam int RATIO_W      = 3;  // built-in resistor ratio width
   localparam int EEP_W        = VOL_W + RATIO_W; // stored word width
   localparam int CMD_W        = 4;  // command code width
   localparam int PWR_SRC_POS  = 4;  // resistor_source_bit position
   localparam int ST_OSC_POS   = 0;  // oscillator running
   localparam int ST_MODE_POS  = 1;  // eeprom control mode active
   localparam int ST_BUSY_POS  = 2;  // eeprom_access_busy_bit
   localparam int ST_TEST_POS  = 3;  // factory test state
   localparam int ST_SEL_POS   = 4;  // readback source, 0 volume 1 ratio

   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic [VOL_W-1:0]   RST_VOLUME = 6'h00;
   localparam logic [RATIO_W-1:0] RST_RATIO  = 3'h0;
   localparam logic [7:0]         RST_POWER  = 8'h00;

   // ---------------------------------------------------------------
   // timing: osc runs at clk / OSC_DIV, counts in osc periods
   // ---------------------------------------------------------------
   localparam int         CLK_HZ      = 40_000_000;
   localparam int         OSC_HZ      = 20_000_000;
   localparam int         OSC_DIV     = CLK_HZ / OSC_HZ;
   localparam int         TMR_W       = 12;
   localparam logic [TMR_W-1:0] ENTER_OSC = 12'(5 * 4);    // mode entry
   localparam logic [TMR_W-1:0] WRITE_OSC = 12'(10 * 320); // memory write
   localparam logic [TMR_W-1:0] READ_OSC  = 12'(10 * 4);   // memory read

   // ---------------------------------------------------------------
   // command codes written to ADDR_CMD
   // ---------------------------------------------------------------
   typedef enum logic [CMD_W-1:0] {
      CMD_NOP        = 4'h0,
      CMD_OSC_ON     = 4'h1,
      CMD_OSC_OFF    = 4'h2,
      CMD_ENTER_WR   = 4'h3,
      CMD_ENTER_RD   = 4'h4,
      CMD_MEM_WRITE  = 4'h5,
      CMD_MEM_READ   = 4'h6,
      CMD_MODE_EXIT  = 4'h7,
      CMD_SEL_ONE    = 4'h8,
      CMD_SEL_TWO    = 4'h9
   } ecr_cmd_e;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ecr_apb_req_s;

   typedef struct packed {
      logic             write_en;  // eeprom write in progress
      logic             read_en;   // eeprom read in progress
      logic [EEP_W-1:0] data;      // word to store
   } ecr_eep_s;

endpackage : ecr_pkg

// >>> hdl/ecr_timer.sv
`timescale 1ns/1ps
// osc period divider and countdown for eeprom processing times
module ecr_timer (
   input  wire logic                    clk_in,
   input  wire logic                    reset_in,
   input  wire logic                    osc_run_in,
   input  wire logic                    start_in,
   input  wire logic [ecr_pkg::TMR_W-1:0] load_in,
   output logic                         done_out
);
   import ecr_pkg::*;

   logic [3:0]       div;        // clk to osc tick divider
   logic [3:0]       next_div;
   logic [TMR_W-1:0] count;      // osc periods left
   logic [TMR_W-1:0] next_count;
   logic             next_done;
   logic             osc_tick;   // one-cycle osc period enable

   // ------------------------------------------------------------
   // next values
   // ------------------------------------------------------------
   always_comb begin
      osc_tick   = osc_run_in && (div == 4'(OSC_DIV - 1));
      next_div   = osc_run_in && !osc_tick ? div + 4'h1 : 4'h0;
      next_count = count;
      next_done  = 1'b0;
      if (start_in) begin                       // reload on start
         next_count = load_in;
         next_div   = 4'h0;
      end else if (osc_tick && count != '0) begin
         next_count = count - 1'b1;
         next_done  = (count == 12'h001);
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         div      <= 4'h0;
         count    <= '0;
         done_out <= 1'b0;
      end else begin
         div      <= next_div;
         count    <= next_count;
         done_out <= next_done;
      end
   end

endmodule : ecr_timer

// >>> tb/ecr_eeprom_ctrl_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker for the eeprom control block
// ---------------------------------------------------------------
module ecr_eeprom_ctrl_assertions #(
   parameter logic [ecr_pkg::TMR_W-1:0] WRITE_OSC_P = ecr_pkg::WRITE_OSC
) (
   input  wire logic                      clk_in,
   input  wire logic                      reset_in,
   input  wire ecr_pkg::ecr_apb_req_s     apb_in,
   input  wire logic                      pready_out,
   input  wire logic [31:0]               prdata_out,
   input  wire logic                      pslverr_out,
   input  wire ecr_pkg::ecr_eep_s         eep_out,
   input  wire logic [ecr_pkg::EEP_W-1:0] eep_data_in,
   input  wire logic                      v1_from_eeprom_out
);
   import ecr_pkg::*;
   // busy windows in clocks, osc tick is two clocks, small slack
   localparam int WR_LO = 2 * int'(WRITE_OSC_P) - 1;
   localparam int WR_HI = 2 * int'(WRITE_OSC_P) + 3;
   localparam int RD_LO = 2 * int'(READ_OSC) - 1;
   localparam int RD_HI = 2 * int'(READ_OSC) + 3;
   logic             acc;           // completed apb access
   logic             bad;           // unmapped address, or write to a read-only word
   logic [CMD_W-1:0] last_cmd;      // last command code written
   logic [CMD_W-1:0] next_last_cmd;
   logic [15:0]      busy_cnt;      // cycles of current eeprom op
   logic [15:0]      next_busy_cnt;
   assign acc = apb_in.psel && apb_in.penable && pready_out;
   // writes reach only the command, volume and power words
   assign bad = acc && (apb_in.pwrite
                ? !(apb_in.paddr inside {ADDR_CMD, ADDR_VOLUME, ADDR_POWER})
                : !(apb_in.paddr inside {ADDR_CMD, ADDR_VOLUME, ADDR_POWER,
                                         ADDR_STATUS, ADDR_READBACK}));
   // next command and op length
   always_comb begin
      next_last_cmd = last_cmd;
      next_busy_cnt = 16'h0;
      if (acc && apb_in.pwrite && apb_in.paddr == ADDR_CMD) begin
         next_last_cmd = apb_in.pwdata[CMD_W-1:0];
      end
      if (eep_out.write_en || eep_out.read_en) begin
         next_busy_cnt = busy_cnt + 16'h1;
      end
   end
   // helper registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         last_cmd <= '0;
         busy_cnt <= '0;
      end else begin
         last_cmd <= next_last_cmd;
         busy_cnt <= next_busy_cnt;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   chk_v1_source: assert property (
      acc && apb_in.pwrite && apb_in.paddr == ADDR_POWER |=>
      v1_from_eeprom_out == !$past(apb_in.pwdata[PWR_SRC_POS]))
      else $error("v1 source does not follow power bit");
   chk_bad_addr: assert property (pslverr_out == bad)
      else $error("slave error not tied to unmapped access");
   chk_write_time: assert property (
      $fell(eep_out.write_en) |-> busy_cnt >= WR_LO && busy_cnt <= WR_HI)
      else $error("eeprom write time wrong");
   chk_read_time: assert property (
      $fell(eep_out.read_en) |-> busy_cnt >= RD_LO && busy_cnt <= RD_HI)
      else $error("eeprom read time wrong");
   chk_one_op: assert property (
      !(eep_out.write_en && eep_out.read_en))
      else $error("read and write overlap");
   chk_word_steady: assert property (
      eep_out.write_en && $past(eep_out.write_en) |-> $stable(eep_out.data))
      else $error("stored word moved during write");
   chk_write_cause: assert property (
      $rose(eep_out.write_en) |-> last_cmd == CMD_MEM_WRITE)
      else $error("write started without write command");
   chk_read_cause: assert property (
      $rose(eep_out.read_en) |-> last_cmd == CMD_MEM_READ)
      else $error("read started without read command");
   cov_write: cover property ($rose(eep_out.write_en));
   cov_read: cover property ($rose(eep_out.read_en));
   cov_error: cover property (pslverr_out);
endmodule : ecr_eeprom_ctrl_assertions

bind ecr_eeprom_ctrl ecr_eeprom_ctrl_assertions #(
   .WRITE_OSC_P(WRITE_OSC_P)
) u_chk (
   .clk_in(clk_in), .reset_in(reset_in), .apb_in(apb_in),
   .pready_out(pready_out), .prdata_out(prdata_out),
   .pslverr_out(pslverr_out), .eep_out(eep_out),
   .eep_data_in(eep_data_in), .v1_from_eeprom_out(v1_from_eeprom_out)
);

// >>> tb/ecr_eeprom_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// external eeprom holding one volume and ratio word
// ---------------------------------------------------------------
module ecr_eeprom_model (
   input  wire logic                      clk_in,
   input  wire ecr_pkg::ecr_eep_s         eep_in,
   output logic [ecr_pkg::EEP_W-1:0]      data_out
);
   import ecr_pkg::*;
   logic [EEP_W-1:0] mem  = 9'h0f3; // stored word, arbitrary start
   logic [1:0]       hold = 2'h0;   // drive tail after a read
   initial data_out = 9'h000;
   // store on write, drive only while read and its short tail
   always @(posedge clk_in) begin
      if (eep_in.write_en) begin
         mem <= eep_in.data;
      end
      if (eep_in.read_en) begin
         hold <= 2'h3;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
      // released line toggles so a stale value is never held steady
      data_out <= (eep_in.read_en || hold != 2'h0) ? mem : ~data_out;
   end
endmodule : ecr_eeprom_model

// >>> tb/ecr_eeprom_ctrl_test.sv
`timescale 1ns/1ps
module ecr_eeprom_ctrl_test;
   import ecr_pkg::*;
   localparam logic [TMR_W-1:0] WR_P = 12'h008; // short write time
   logic             clk_in;
   logic             reset_in;
   ecr_apb_req_s     apb;        // apb request to the block
   logic             pready;
   logic [31:0]      prdata;
   logic             slverr;
   ecr_eep_s         eep;        // eeprom control lines
   logic [EEP_W-1:0] eep_rd;     // word from eeprom
   logic             v1;
   logic [31:0]      rd;         // last read data
   logic             err;        // last slave error
   int               n_mismatch;
   int               checked;
   ecr_eeprom_ctrl #(.WRITE_OSC_P(WR_P)) uut (
      .clk_in(clk_in), .reset_in(reset_in), .apb_in(apb),
      .pready_out(pready), .prdata_out(prdata), .pslverr_out(slverr),
      .eep_out(eep), .eep_data_in(eep_rd), .v1_from_eeprom_out(v1));
   ecr_eeprom_model partner (
      .clk_in(clk_in), .eep_in(eep), .data_out(eep_rd));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic wrap_up;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // one apb transfer, data taken at the ready edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int i;
      @(posedge clk_in);
      apb <= {1'b1, 1'b0, w, a, d};
      @(posedge clk_in);
      apb.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (pready === 1'b1) break;
      end
      rd  = prdata;
      err = slverr;
      apb <= '0;
      if (i == 20) begin
         n_mismatch++;
         $display("[FAIL] %0t no ready on apb", $time);
         wrap_up();
      end else begin
         @(posedge clk_in);   // let the write settle before checks
      end
   endtask : xfer
   task automatic cmd(input ecr_cmd_e c);
      xfer(1'b1, ADDR_CMD, {28'h0, c});
   endtask : cmd
   task automatic check_rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : check_rd
   // poll the busy bit, bounded
   task automatic wait_idle;
      int k;
      for (k = 0; k < 300; k++) begin
         xfer(1'b0, ADDR_STATUS, 32'h0);
         if (rd[ST_BUSY_POS] === 1'b0) break;
      end
      if (k == 300) begin
         n_mismatch++;
         $display("[FAIL] %0t busy never cleared", $time);
         wrap_up();
      end
   endtask : wait_idle
   // ---------------------------------------------------------------
   // clock and sequence
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      reset_in = 1'b1;
      apb = '0;
      n_mismatch = 0;
      checked = 0;
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      check_rd(ADDR_STATUS, 32'h8);
      check({31'h0, v1}, 32'h1);
      cmd(CMD_NOP);
      check_rd(ADDR_STATUS, 32'h0);
      xfer(1'b1, ADDR_POWER, 32'h10);
      check({31'h0, v1}, 32'h0);
      check_rd(ADDR_POWER, 32'h10);
      xfer(1'b1, ADDR_POWER, 32'h0);
      check({31'h0, v1}, 32'h1);
      cmd(CMD_OSC_ON);
      // store sequence with a refused command and refused volume
      xfer(1'b1, ADDR_VOLUME, 32'h16a);
      cmd(CMD_ENTER_WR);
      wait_idle();
      check_rd(ADDR_STATUS, 32'h3);
      cmd(CMD_MEM_READ);
      check_rd(ADDR_STATUS, 32'h3);
      cmd(CMD_MEM_WRITE);
      check_rd(ADDR_STATUS, 32'h7);
      xfer(1'b1, ADDR_VOLUME, 32'h1ff);
      wait_idle();
      cmd(CMD_MODE_EXIT);
      check({23'h0, partner.mem}, 32'h16a);
      check_rd(ADDR_VOLUME, 32'h16a);
      check_rd(ADDR_STATUS, 32'h1);
      // restore sequence, values load only at exit
      xfer(1'b1, ADDR_VOLUME, 32'h015);
      cmd(CMD_ENTER_RD);
      wait_idle();
      cmd(CMD_MEM_READ);
      check_rd(ADDR_STATUS, 32'h7);
      wait_idle();
      check_rd(ADDR_VOLUME, 32'h015);
      cmd(CMD_MODE_EXIT);
      check_rd(ADDR_VOLUME, 32'h16a);
      // readback of both values
      cmd(CMD_SEL_ONE);
      check_rd(ADDR_READBACK, 32'h2a);
      cmd(CMD_SEL_TWO);
      check_rd(ADDR_READBACK, 32'h5);
      check_rd(ADDR_STATUS, 32'h11);
      // unmapped address
      xfer(1'b0, 8'h20, 32'h0);
      check({31'h0, err}, 32'h1);
      xfer(1'b1, 8'h20, 32'h0);
      check({31'h0, err}, 32'h1);
      // oscillator off, then reset in mid-run
      cmd(CMD_OSC_OFF);
      check_rd(ADDR_STATUS, 32'h10);
      @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      check_rd(ADDR_STATUS, 32'h8);
      check_rd(ADDR_VOLUME, 32'h0);
      // refresh without timing control, no-operation included
      cmd(CMD_OSC_ON);
      xfer(1'b1, ADDR_VOLUME, 32'h16a);
      xfer(1'b1, ADDR_POWER, 32'h10);
      check({31'h0, v1}, 32'h0);
      cmd(CMD_NOP);
      check_rd(ADDR_STATUS, 32'h1);
      check_rd(ADDR_VOLUME, 32'h16a);
      wrap_up();
   end
endmodule : ecr_eeprom_ctrl_test
